// ==== hdl/serirq_pkg.sv ====
// shared constants, types and slot arithmetic for the serial interrupt link
package serirq_pkg;

  // ---------------------------------------------------------------
  // frame geometry
  // ---------------------------------------------------------------
  localparam int               NUM_IRQ         = 16;
  localparam int               NUM_PERIODS     = 21;
  localparam int               IOCHK_PERIOD    = 17;
  localparam int               SLOT_STEP       = 3;
  localparam int               SLOT_OFFSET     = 1;
  localparam int               CNT_W           = 7;
  // irq 3,4,5,6,7,9,10,11,12,14,15 are the only serialized inputs
  localparam logic [15:0]      SERIAL_IRQ_MASK = 16'hDEF8;
  // first clock past the start edge that may carry a stop pulse
  localparam logic [CNT_W-1:0] STOP_AT         = 7'h41;
  localparam logic [CNT_W-1:0] CNT_MAX         = 7'h7F;

  // ---------------------------------------------------------------
  // pulse lengths in clocks
  // ---------------------------------------------------------------
  localparam logic [2:0]       START_CLKS       = 3'h4;
  localparam logic [2:0]       SLAVE_START_CLKS = 3'h1;
  localparam logic [2:0]       STOP_QUIET_CLKS  = 3'h2;
  localparam logic [2:0]       STOP_CONT_CLKS   = 3'h3;
  localparam logic [2:0]       IDLE_GAP_CLKS    = 3'h2;

  typedef enum {ST_IDLE, ST_START, ST_WAIT_RISE, ST_FRAMES, ST_STOP, ST_GAP} link_state_t;

  // drive clock of a period, counted past the start pulse rising edge
  function automatic logic [CNT_W-1:0] slot_clk(input int period);
    slot_clk = CNT_W'(SLOT_STEP * period - SLOT_OFFSET);
  endfunction : slot_clk

endpackage : serirq_pkg

// ==== hdl/serirq_if.sv ====
// shared serial interrupt wire with pull-up and one modport per end
`timescale 1ns/1ps
interface serirq_if;
  // slave end drive
  logic dev_out;
  logic dev_oe_n;
  // master end drive
  logic mst_out;
  logic mst_oe_n;
  // further slaves modelled by the bench, high when none pulls low
  logic others_level;
  // resolved level, the pull-up wins when nobody drives low
  logic wire_level;

  assign wire_level = (dev_oe_n | dev_out) & (mst_oe_n | mst_out) & others_level;

  modport dev  (output dev_out, output dev_oe_n, input wire_level);
  modport host (output mst_out, output mst_oe_n, input wire_level);
endinterface : serirq_if

// ==== hdl/serirq_slave.sv ====
// slave end of the serial interrupt link: serializes legacy irq levels
// What this block does
// - all wire timing counted in clock cycles
// - slave in quiet and continuous modes
// - wire undriven between stop and start
// - quiet mode: pending request starts a start cycle
// - no extra start while sequence still usable
// - quiet mode: watch stop before new start
// - continuous mode: never begin a start cycle
// - continuous mode: track start and stop frames
// - count sample periods from start rising edge
// - low input drives wire low in slot
// - irq n drives at 3(n+1)-1 clocks
// - only irq 3-7,9-12,14,15 serialized
// - no reconfiguration while transfer runs
// - reserved periods undriven, iochk in period 17
`timescale 1ns/1ps
module serirq_slave (
  // clock and reset
  input  wire logic                            clk,
  input  wire logic                            rst_n,
  // link
  serirq_if.dev                                link,
  // configuration, held steady while busy
  input  wire logic                            continuous_mode,
  // legacy request levels, low means request
  input  wire logic [serirq_pkg::NUM_IRQ-1:0]  irq_n,
  input  wire logic                            iochk_n,
  // status
  output logic                                 busy
);
  import serirq_pkg::*;

  link_state_t        state;
  logic [CNT_W-1:0]   cnt;
  logic [CNT_W-1:0]   next_cnt;
  logic [2:0]         start_cnt;
  logic               prev_level;
  logic               rise;
  logic               slot_drive;
  logic               slot_hit;
  logic               start_drive;
  logic               pending;
  logic               go_start;
  logic [NUM_IRQ-1:0] sent;
  logic               sent_iochk;
  logic               drive_low;
  logic               drive_any;

  // ---------------------------------------------------------------
  // slot arithmetic
  // ---------------------------------------------------------------
  // true when a count is the drive clock of a period; the same match
  // places the drive and records what the slot carried
  function automatic logic at_slot(input logic [CNT_W-1:0] count, input int period);
    at_slot = (count == slot_clk(period));
  endfunction : at_slot

  // ---------------------------------------------------------------
  // edge detection and counting
  // ---------------------------------------------------------------
  // a rise only counts while waiting for the start to end, so slot
  // pulses inside a frame never restart the count
  assign rise     = ~prev_level & link.wire_level;
  assign next_cnt = CNT_W'(cnt + 1'b1);

  // previous wire level for the rising edge
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prev_level <= 1'b1;
    end else begin
      prev_level <= link.wire_level;
    end
  end

  // a change not yet carried in its slot stays pending
  assign pending  = (|((irq_n ^ sent) & SERIAL_IRQ_MASK)) | (iochk_n ^ sent_iochk);
  // limitation: a level that toggles and returns within one frame is
  // never seen, since only the level at the slot clock is compared
  // only an idle wire may be started, and only in quiet mode
  assign go_start = (state == ST_IDLE) && !continuous_mode && pending && link.wire_level;

  // ---------------------------------------------------------------
  // link state
  // ---------------------------------------------------------------
  // frame timeline in clocks, shared by every party on the wire:
  //   start - wire low four clocks; in quiet mode the first may be ours
  //   rise  - first clock edge that samples the wire high again
  //   cnt 0 - the clock after the rise; period p drives at cnt 3p-1
  //   slot  - low at 3p-1, driven high at 3p, released from 3p+1
  //   stop  - master low from cnt 65, two clocks quiet, three continuous
  //   idle  - nobody drives, the pull-up holds the wire high
  // hazard: a master lost in mid-frame never sends the stop; the count
  // ceiling drops us back to idle so the next start is still seen
  // one machine serves both modes; continuous just never starts
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state     <= ST_IDLE;
      cnt       <= '0;
      start_cnt <= '0;
    end else begin
      case (state)
        ST_IDLE: begin
          if (!link.wire_level) begin
            state <= ST_WAIT_RISE; // another party started
          end else if (go_start) begin
            state     <= ST_START;
            start_cnt <= '0;
          end
        end
        ST_START: begin
          start_cnt <= start_cnt + 3'h1;
          if (start_cnt >= SLAVE_START_CLKS - 3'h1) begin
            state <= ST_WAIT_RISE;
          end
        end
        ST_WAIT_RISE: begin
          if (rise) begin
            state <= ST_FRAMES;
            cnt   <= '0;
          end
        end
        ST_FRAMES: begin
          cnt <= next_cnt;
          if (cnt >= STOP_AT && !link.wire_level) begin
            state <= ST_STOP; // stop pulse seen
          end else if (cnt == CNT_MAX) begin
            state <= ST_IDLE; // lost frame, resynchronise on next start
          end
        end
        ST_STOP: begin
          if (link.wire_level) begin
            state <= ST_IDLE;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // slot selection
  // ---------------------------------------------------------------
  // hit when the coming cycle is the slot of an active request
  // reserved periods and unserialized inputs never match, so stay released
  always_comb begin
    slot_hit = 1'b0;
    for (int i = 0; i < NUM_IRQ; i++) begin
      if (SERIAL_IRQ_MASK[i] && !irq_n[i] && at_slot(next_cnt, i + 1)) begin
        slot_hit = 1'b1;
      end
    end
    if (!iochk_n && at_slot(next_cnt, IOCHK_PERIOD)) begin
      slot_hit = 1'b1;
    end
  end

  assign start_drive = go_start || (state == ST_START && start_cnt < SLAVE_START_CLKS - 3'h1);

  // remember what each slot carried so quiet mode can see changes
  // reset assumes every input released, so nothing is pending at first
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sent       <= '1;
      sent_iochk <= 1'b1;
    end else if (state == ST_FRAMES) begin
      for (int i = 0; i < NUM_IRQ; i++) begin
        if (at_slot(cnt, i + 1)) begin
          sent[i] <= irq_n[i];
        end
      end
      if (at_slot(cnt, IOCHK_PERIOD)) begin
        sent_iochk <= iochk_n;
      end
    end
  end

  // ---------------------------------------------------------------
  // pin drive
  // ---------------------------------------------------------------
  // the recovery clock only adds the enable: the wire is driven back high
  // for one clock, so the pull-up never has to lift it alone
  assign drive_low = start_drive | ((state == ST_FRAMES) && slot_hit);
  assign drive_any = drive_low | slot_drive;

  // low in the slot or the start clock, one high recovery clock after a slot, else released
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      slot_drive   <= 1'b0;
      link.dev_out  <= 1'b1;
      link.dev_oe_n <= 1'b1;
    end else begin
      slot_drive    <= (state == ST_FRAMES) && slot_hit;
      link.dev_out  <= ~drive_low;
      link.dev_oe_n <= ~drive_any;
    end
  end

  // status flag, one clock behind the machine
  // high while a frame runs: the time in which reconfiguring is unsafe
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      busy <= 1'b0;
    end else begin
      busy <= (state != ST_IDLE);
    end
  end

endmodule : serirq_slave

// ==== hdl/serirq_master.sv ====
// master end of the serial interrupt link: frames the wire, collects slots
`timescale 1ns/1ps
module serirq_master (
  // clock and reset
  input  wire logic                                clk,
  input  wire logic                                rst_n,
  // link
  serirq_if.host                                   link,
  // configuration, changed only while idle
  input  wire logic                                continuous_mode,
  // collected levels, bit p is period p, low means request
  output logic [serirq_pkg::NUM_PERIODS:1]         irq_frames,
  output logic                                     frame_done
);
  import serirq_pkg::*;

  link_state_t          state;
  link_state_t          next_state;
  logic [CNT_W-1:0]     cnt;
  logic [2:0]           ph_cnt;
  logic [2:0]           stop_len;
  logic                 prev_level;
  logic                 rise;
  logic [NUM_PERIODS:1] shadow;

  // ---------------------------------------------------------------
  // state decode
  // ---------------------------------------------------------------
  assign rise     = ~prev_level & link.wire_level;
  assign stop_len = continuous_mode ? STOP_CONT_CLKS : STOP_QUIET_CLKS;

  // next state feeds the registered pin so the drive is glitch free
  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (continuous_mode || !link.wire_level) begin
          next_state = ST_START;
        end
      end
      ST_START: begin
        if (ph_cnt >= START_CLKS - 3'h1) begin
          next_state = ST_WAIT_RISE;
        end
      end
      ST_WAIT_RISE: begin
        if (rise) begin
          next_state = ST_FRAMES;
        end
      end
      ST_FRAMES: begin
        if (cnt == STOP_AT - 7'h01) begin
          next_state = ST_STOP;
        end
      end
      ST_STOP: begin
        if (ph_cnt >= stop_len - 3'h1) begin
          next_state = continuous_mode ? ST_GAP : ST_IDLE;
        end
      end
      ST_GAP: begin
        if (ph_cnt >= IDLE_GAP_CLKS - 3'h1) begin
          next_state = ST_IDLE;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  // ---------------------------------------------------------------
  // counters and state
  // ---------------------------------------------------------------
  // a slave start already spent one low clock, so count it
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state      <= ST_IDLE;
      cnt        <= '0;
      ph_cnt     <= '0;
      prev_level <= 1'b1;
    end else begin
      state      <= next_state;
      prev_level <= link.wire_level;
      cnt        <= (state == ST_FRAMES) ? CNT_W'(cnt + 1'b1) : '0;
      if (next_state != state) begin
        ph_cnt <= (state == ST_IDLE && !continuous_mode) ? SLAVE_START_CLKS : 3'h0;
      end else begin
        ph_cnt <= ph_cnt + 3'h1;
      end
    end
  end

  // ---------------------------------------------------------------
  // slot capture
  // ---------------------------------------------------------------
  // shadow keeps the live frame, published only once it is complete
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      shadow     <= '1;
      irq_frames <= '1;
      frame_done <= 1'b0;
    end else begin
      frame_done <= 1'b0;
      if (state == ST_FRAMES) begin
        for (int p = 1; p <= NUM_PERIODS; p++) begin
          if (cnt == slot_clk(p)) begin
            shadow[p] <= link.wire_level;
          end
        end
      end
      if (state == ST_STOP && next_state != ST_STOP) begin
        irq_frames <= shadow;
        frame_done <= 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // pin drive
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      link.mst_out  <= 1'b1;
      link.mst_oe_n <= 1'b1;
    end else begin
      link.mst_out  <= ~(next_state == ST_START || next_state == ST_STOP);
      link.mst_oe_n <= ~(next_state == ST_START || next_state == ST_STOP);
    end
  end

endmodule : serirq_master

// ==== testbench/serirq_link_chk.sv ====
// concurrent checks on the shared serial interrupt wire
`timescale 1ns/1ps
module serirq_link_chk (
  // clock, reset and mode
  input wire logic clk,
  input wire logic rst_n,
  input wire logic continuous_mode,
  // interface signals
  input wire logic dev_out,
  input wire logic dev_oe_n,
  input wire logic mst_out,
  input wire logic mst_oe_n,
  input wire logic wire_level
);
  logic       in_frame;
  logic [6:0] cnt;
  logic       prev_level;

  // ----------------------------------------
  // frame tracker
  // ----------------------------------------
  // count zero is the cycle after the start rise; slot pulses inside a frame are no rise
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      in_frame   <= 1'b0;
      cnt        <= 7'h00;
      prev_level <= 1'b1;
    end else begin
      prev_level <= wire_level;
      if (!in_frame && wire_level && !prev_level) begin
        in_frame <= 1'b1;
        cnt      <= 7'h00;
      end else if (in_frame) begin
        cnt <= cnt + 7'h01;
        if (cnt == 7'h44) in_frame <= 1'b0; // past the longest stop pulse
      end
    end
  end

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence slot_low;
    in_frame && !dev_oe_n && !dev_out;
  endsequence
  sequence recover_release;
    !dev_oe_n && dev_out ##1 dev_oe_n;
  endsequence

  slot_position_a: assert property (slot_low |-> ((cnt + 7'h01) % 7'h03) == 7'h00 && cnt >= 7'h0B && cnt <= 7'h32)
    else $error("slave drove low off a slot clock");
  reserved_idle_a: assert property (slot_low |-> cnt != 7'h1A && cnt != 7'h29)
    else $error("slave drove a reserved period");
  slot_recover_a: assert property (slot_low |=> recover_release)
    else $error("slot low not followed by recovery and release");
  late_release_a: assert property (in_frame && cnt > 7'h33 |-> dev_oe_n)
    else $error("slave drove after its last slot");
  cont_no_start_a: assert property (continuous_mode && !in_frame |-> dev_oe_n)
    else $error("slave drove outside a frame in continuous mode");
  slave_start_a: assert property (!in_frame && !dev_oe_n |-> !continuous_mode && !dev_out ##1 dev_oe_n)
    else $error("slave start pulse malformed");
  start_pulse_a: assert property (!in_frame && $fell(wire_level) |=> !wire_level [*3] ##1 wire_level)
    else $error("start pulse not four clocks");
  stop_pulse_a: assert property (in_frame && cnt == 7'h41 |->
    !wire_level ##1 !wire_level ##1 (continuous_mode ? !wire_level : wire_level))
    else $error("stop pulse length wrong");
  master_off_a: assert property (in_frame && cnt < 7'h41 |-> mst_oe_n)
    else $error("master drove inside the slot periods");
endmodule : serirq_link_chk

// ==== testbench/tb_serial_irq_slave.sv ====
// self-checking bench: serial interrupt slave facing the master end
`timescale 1ns/1ps
module tb_serial_irq_slave;
  import serirq_pkg::*;
  logic                 clk;
  logic                 rst_n;
  logic                 continuous_mode;
  logic [NUM_IRQ-1:0]   irq_n;
  logic                 iochk_n;
  logic                 busy;
  logic [NUM_PERIODS:1] irq_frames;
  logic                 frame_done;
  int                   errors = 0;
  int                   cmp_count = 0;
  int                   frames = 0;
  int                   cycles = 0;
  int                   f0;

  serirq_if serirq_if_i ();
  serirq_slave serirq_slave_i (.clk(clk), .rst_n(rst_n), .link(serirq_if_i), .continuous_mode(continuous_mode),
    .irq_n(irq_n), .iochk_n(iochk_n), .busy(busy));
  serirq_master serirq_master_i (.clk(clk), .rst_n(rst_n), .link(serirq_if_i), .continuous_mode(continuous_mode),
    .irq_frames(irq_frames), .frame_done(frame_done));
  serirq_link_chk serirq_link_chk_i (.clk(clk), .rst_n(rst_n), .continuous_mode(continuous_mode),
    .dev_out(serirq_if_i.dev_out), .dev_oe_n(serirq_if_i.dev_oe_n), .mst_out(serirq_if_i.mst_out),
    .mst_oe_n(serirq_if_i.mst_oe_n), .wire_level(serirq_if_i.wire_level));

  // 100 MHz clock
  initial clk = 1'b0;
  always #5 clk = ~clk;

  // frame counter and hang guard at the falling edge, where frame_done has settled; run needs under 10000 cycles
  always @(negedge clk) begin
    cycles++;
    if (frame_done === 1'b1) frames++;
    if (cycles == 20000) begin
      errors++;
      $display("[ERR] %0t run timed out", $time);
      conclude();
    end
  end

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : cmp

  // expected frame image: only serialized inputs and the channel check show up
  function automatic logic [NUM_PERIODS:1] expect_of(input logic [NUM_IRQ-1:0] irq, input logic chk);
    logic [NUM_PERIODS:1] e;
    e = '1;
    for (int n = 0; n < NUM_IRQ; n++) if (SERIAL_IRQ_MASK[n] && !irq[n]) e[n+1] = 1'b0;
    e[IOCHK_PERIOD] = chk;
    return e;
  endfunction : expect_of

  task automatic wait_frames(input int k);
    int start;
    start = frames;
    while (frames < start + k) @(negedge clk);
  endtask : wait_frames

  // continuous mode needs two frames: the first may already be past some slots
  task automatic send(input logic [NUM_IRQ-1:0] irq, input logic chk, input int k);
    @(negedge clk);
    irq_n = irq;
    iochk_n = chk;
    wait_frames(k);
    cmp({11'h000, irq_frames}, {11'h000, expect_of(irq, chk)});
  endtask : send

  task automatic do_reset(input logic mode);
    @(negedge clk);
    rst_n = 1'b0;
    continuous_mode = mode; // mode only changes while held in reset
    irq_n = 16'hFFFF;
    iochk_n = 1'b1;
    repeat (10) @(negedge clk);
    rst_n = 1'b1;
  endtask : do_reset

  task automatic conclude;
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : conclude

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    rst_n = 1'b0;
    continuous_mode = 1'b0;
    irq_n = 16'hFFFF;
    iochk_n = 1'b1;
    serirq_if_i.others_level = 1'b1;
    repeat (10) @(negedge clk);
    rst_n = 1'b1;
    // quiet and nothing pending: wire stays idle
    repeat (200) @(negedge clk);
    cmp(frames, 0);
    cmp({31'h0, busy}, 32'h0);
    // another slave starts; one request joins in time, one misses its slot
    f0 = frames;
    serirq_if_i.others_level = 1'b0;
    @(negedge clk);
    serirq_if_i.others_level = 1'b1;
    repeat (10) @(negedge clk);
    irq_n[15] = 1'b0;
    cmp({31'h0, busy}, 32'h1);
    repeat (35) @(negedge clk);
    irq_n[3] = 1'b0;
    wait_frames(1);
    cmp({11'h000, irq_frames}, {11'h000, expect_of(16'h7FFF, 1'b1)});
    wait_frames(1);
    cmp({11'h000, irq_frames}, {11'h000, expect_of(16'h7FF7, 1'b1)});
    repeat (200) @(negedge clk);
    cmp(frames, f0 + 2);
    // walk every input in both modes; channel check toggles so each step changes
    for (int m = 0; m < 2; m++) begin
      do_reset(m[0]);
      for (int n = 0; n < NUM_IRQ; n++) send(~(16'h0001 << n), n[0], m + 1);
    end
    send(16'h0000, 1'b0, 2);
    send(16'hFFFF, 1'b1, 2);
    send(16'h5A5A, 1'b0, 2);
    conclude();
  end
endmodule : tb_serial_irq_slave
